//--- rtl/eirq_cfg.svh
// Register offsets, field positions, reset values and timing figures of the interrupt block
`ifndef EIRQ_CFG_SVH
`define EIRQ_CFG_SVH

`define EIRQ_ADDR_W          8
`define EIRQ_OFS_STATUS      8'h58
`define EIRQ_OFS_ENABLE      8'h5C
`define EIRQ_OFS_PROBE       8'h64
`define EIRQ_OFS_LEVEL       8'h68
`define EIRQ_OFS_CTRL        8'h70
`define EIRQ_OFS_STATE       8'h74

`define EIRQ_BIT_SOFT        31
`define EIRQ_BIT_TX_DONE     21
`define EIRQ_BIT_RX_XFER     20
`define EIRQ_BIT_TIMER       19
`define EIRQ_BIT_PHY         18
`define EIRQ_BIT_POWER       17
`define EIRQ_BIT_TXS_OVF     16
`define EIRQ_BIT_RX_OVSZ     15
`define EIRQ_BIT_RX_ERR      14
`define EIRQ_BIT_TX_ERR      13
`define EIRQ_BIT_TXD_OVR     10
`define EIRQ_BIT_TXD_SPACE   9
`define EIRQ_BIT_TXS_FULL    8
`define EIRQ_BIT_TXS_LEVEL   7
`define EIRQ_BIT_RX_DROP     6
`define EIRQ_BIT_RXS_FULL    4
`define EIRQ_BIT_RXS_LEVEL   3

// Writable mask: bits 30:26, 22, 12:11 and 5 stay zero
`define EIRQ_ENABLE_WMASK    32'h83BF_E7DF
// Clearable flags: same set as enable, minus the PHY reflection
`define EIRQ_STATUS_W1C      32'h83BB_E7DF
`define EIRQ_ENABLE_RST      32'h0000_0000

`define EIRQ_LVL_TXSPACE_MSB 31
`define EIRQ_LVL_TXSPACE_LSB 24
`define EIRQ_LVL_TXSTAT_MSB  23
`define EIRQ_LVL_TXSTAT_LSB  16
`define EIRQ_LVL_RXSTAT_MSB  7
`define EIRQ_LVL_RXSTAT_LSB  0
`define EIRQ_LEVEL_RST       32'h4800_0000

`define EIRQ_CTRL_SOFT_BIT   0
`define EIRQ_CTRL_PIN_LSB    1
`define EIRQ_CTRL_RST        32'h0000_0000

`define EIRQ_TIMER_WRAP      16'hFFFF
`define EIRQ_OVERSIZE_BYTES  12'h800
`define EIRQ_PROBE_VALUE     32'h8765_4321

`endif

//--- rtl/eirq_pkg.sv
// Types shared by the interrupt status and enable block
package eirq_pkg;

    typedef struct packed {
        logic        tx_buffer_done;
        logic        rx_xfer_done;
        logic        timer_tick;
        logic [15:0] timer_value;
        logic        phy_event;
        logic        power_event;
        logic        tx_status_overflow;
        logic        rx_frame_end;
        logic [11:0] rx_frame_bytes;
        logic        rx_error;
        logic        tx_error;
        logic        tx_data_write;
        logic        tx_data_full;
        logic [7:0]  tx_free_blocks;
        logic        tx_status_full;
        logic [7:0]  tx_status_used;
        logic        rx_frame_drop;
        logic        rx_status_full;
        logic [7:0]  rx_status_used;
    } eirq_src_type;

    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } eirq_bus_type;

    typedef enum logic [1:0] {
        EIRQ_AWAKE,
        EIRQ_ASLEEP
    } eirq_pwr_type;

endpackage : eirq_pkg

//--- rtl/eirq_pin_edge.sv
// Per-pin synchroniser and rising or falling edge detector for the three pin events
`include "eirq_cfg.svh"
module eirq_pin_edge
    import eirq_pkg::*;
(
    input  wire logic       ref_clk,
    input  wire logic       rst,
    input  wire logic [2:0] pin_in,
    input  wire logic [2:0] pin_enable,
    input  wire logic [2:0] pin_falling,
    output logic      [2:0] pin_event
);
    logic [2:0] sync1_ff;
    logic [2:0] sync2_ff;
    logic [2:0] last_ff;

    // Two flops before anything looks at the pins
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            sync1_ff <= 3'h0;
            sync2_ff <= 3'h0;
            last_ff  <= 3'h0;
        end else begin
            sync1_ff <= pin_in;
            sync2_ff <= sync1_ff;
            last_ff  <= sync2_ff;
        end
    end

    always_comb begin
        pin_event = pin_enable & ((~pin_falling & sync2_ff & ~last_ff) |
                                  (pin_falling & ~sync2_ff & last_ff));
    end

endmodule : eirq_pin_edge

//--- rtl/eirq_core.sv
// Interrupt status and enable registers with master interrupt and wake logic
`include "eirq_cfg.svh"
module eirq_core
    import eirq_pkg::*;
(
    input  wire logic         ref_clk,
    input  wire logic         rst,
    input  wire eirq_bus_type bus,
    output logic       [31:0] rd_data,
    input  wire eirq_src_type src,
    input  wire logic   [2:0] pin_in,
    input  wire logic         deassert_hold,
    output logic              irq_master,
    output logic              irq_out,
    output logic              wake_up,
    output logic              asleep
);
    logic [31:0]  status_ff;
    logic [31:0]  enable_ff;
    logic [31:0]  level_ff;
    logic [31:0]  ctrl_ff;
    logic [31:0]  rd_data_ff;
    logic         irq_master_ff;
    logic         irq_out_ff;
    logic         wake_ff;
    logic         asleep_ff;
    eirq_pwr_type pwr_ff;
    logic [31:0]  events;
    logic [31:0]  clear_bits;
    logic [31:0]  nxt_status;
    logic [31:0]  nxt_rd_data;
    logic [2:0]   pin_event;
    logic [15:0]  timer_last_ff;
    logic         phy_sync1_ff;
    logic         phy_sync2_ff;
    logic         phy_bit;
    logic         any_active;
    logic         power_active;

    function automatic logic wr_hit(input eirq_bus_type b, input logic [7:0] ofs);
        wr_hit = b.wr && (b.addr == ofs);
    endfunction : wr_hit

    function automatic logic [7:0] lvl_field(input logic [31:0] r, input int lsb);
        lvl_field = r[lsb +: 8];
    endfunction : lvl_field

    eirq_pin_edge u_pin_edge (
        .ref_clk     (ref_clk),
        .rst         (rst),
        .pin_in      (pin_in),
        .pin_enable  (ctrl_ff[`EIRQ_CTRL_PIN_LSB +: 3]),
        .pin_falling (ctrl_ff[`EIRQ_CTRL_PIN_LSB + 3 +: 3]),
        .pin_event   (pin_event)
    );

    // PHY event comes from another block on its own timing
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            phy_sync1_ff <= 1'b0;
            phy_sync2_ff <= 1'b0;
        end else begin
            phy_sync1_ff <= src.phy_event;
            phy_sync2_ff <= phy_sync1_ff;
        end
    end
    assign phy_bit = phy_sync2_ff;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            timer_last_ff <= 16'h0000;
        end else begin
            timer_last_ff <= src.timer_value;
        end
    end

    always_comb begin
        events = 32'h0000_0000;
        events[`EIRQ_BIT_SOFT]      = ctrl_ff[`EIRQ_CTRL_SOFT_BIT];
        events[`EIRQ_BIT_TX_DONE]   = src.tx_buffer_done;
        events[`EIRQ_BIT_RX_XFER]   = src.rx_xfer_done;
        events[`EIRQ_BIT_TIMER]     = src.timer_tick && (timer_last_ff == 16'h0000)
                                      && (src.timer_value == `EIRQ_TIMER_WRAP);
        events[`EIRQ_BIT_POWER]     = src.power_event;
        events[`EIRQ_BIT_TXS_OVF]   = src.tx_status_overflow;
        events[`EIRQ_BIT_RX_OVSZ]   = src.rx_frame_end &&
                                      (src.rx_frame_bytes > `EIRQ_OVERSIZE_BYTES);
        events[`EIRQ_BIT_RX_ERR]    = src.rx_error;
        events[`EIRQ_BIT_TX_ERR]    = src.tx_error;
        events[`EIRQ_BIT_TXD_OVR]   = src.tx_data_write && src.tx_data_full;
        events[`EIRQ_BIT_TXD_SPACE] = src.tx_free_blocks >
                                      lvl_field(level_ff, `EIRQ_LVL_TXSPACE_LSB);
        events[`EIRQ_BIT_TXS_FULL]  = src.tx_status_full;
        events[`EIRQ_BIT_TXS_LEVEL] = src.tx_status_used >
                                      lvl_field(level_ff, `EIRQ_LVL_TXSTAT_LSB);
        events[`EIRQ_BIT_RX_DROP]   = src.rx_frame_drop;
        events[`EIRQ_BIT_RXS_FULL]  = src.rx_status_full;
        events[`EIRQ_BIT_RXS_LEVEL] = src.rx_status_used >
                                      lvl_field(level_ff, `EIRQ_LVL_RXSTAT_LSB);
        events[2:0]                 = pin_event;
    end

    // Set wins over clear so an event in the acknowledge cycle survives
    always_comb begin
        clear_bits = 32'h0000_0000;
        if (wr_hit(bus, `EIRQ_OFS_STATUS)) begin
            clear_bits = bus.wdata & `EIRQ_STATUS_W1C;
        end
        nxt_status = ((status_ff & ~clear_bits) | events) & `EIRQ_STATUS_W1C;
        nxt_status[`EIRQ_BIT_PHY] = phy_bit;
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            status_ff <= 32'h0000_0000;
        end else begin
            status_ff <= nxt_status;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            enable_ff <= `EIRQ_ENABLE_RST;
        end else if (wr_hit(bus, `EIRQ_OFS_ENABLE)) begin
            enable_ff <= bus.wdata & `EIRQ_ENABLE_WMASK;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            level_ff <= `EIRQ_LEVEL_RST;
        end else if (wr_hit(bus, `EIRQ_OFS_LEVEL)) begin
            level_ff <= bus.wdata & 32'hFFFF_00FF;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            ctrl_ff <= `EIRQ_CTRL_RST;
        end else if (wr_hit(bus, `EIRQ_OFS_CTRL)) begin
            ctrl_ff <= bus.wdata & 32'h0000_007F;
        end
    end

    // Master line ignores the hold-off; the pin output honours it except for an enabled power event
    always_comb begin
        any_active   = |(status_ff & enable_ff);
        power_active = status_ff[`EIRQ_BIT_POWER] & enable_ff[`EIRQ_BIT_POWER];
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            irq_master_ff <= 1'b0;
            irq_out_ff    <= 1'b0;
        end else begin
            irq_master_ff <= any_active;
            irq_out_ff    <= (any_active && !deassert_hold) || power_active;
        end
    end

    // Power events only flag status; sleep ends solely on a probe write
    // Sleep flag is its own flop so the output needs no decode after the register
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            pwr_ff    <= EIRQ_AWAKE;
            wake_ff   <= 1'b0;
            asleep_ff <= 1'b0;
        end else begin
            wake_ff <= 1'b0;
            case (pwr_ff)
                EIRQ_AWAKE: begin
                    if (wr_hit(bus, `EIRQ_OFS_CTRL) && bus.wdata[7]) begin
                        pwr_ff    <= EIRQ_ASLEEP;
                        asleep_ff <= 1'b1;
                    end
                end
                EIRQ_ASLEEP: begin
                    if (wr_hit(bus, `EIRQ_OFS_PROBE)) begin
                        pwr_ff    <= EIRQ_AWAKE;
                        wake_ff   <= 1'b1;
                        asleep_ff <= 1'b0;
                    end
                end
                default: begin
                    pwr_ff    <= EIRQ_AWAKE;
                    asleep_ff <= 1'b0;
                end
            endcase
        end
    end

    always_comb begin
        nxt_rd_data = 32'h0000_0000;
        if (bus.rd) begin
            case (bus.addr)
                `EIRQ_OFS_STATUS: nxt_rd_data = status_ff;
                `EIRQ_OFS_ENABLE: nxt_rd_data = enable_ff;
                `EIRQ_OFS_PROBE:  nxt_rd_data = `EIRQ_PROBE_VALUE;
                `EIRQ_OFS_LEVEL:  nxt_rd_data = level_ff;
                `EIRQ_OFS_CTRL:   nxt_rd_data = ctrl_ff;
                `EIRQ_OFS_STATE:  nxt_rd_data = {30'h0, irq_out_ff, irq_master_ff};
                default:          nxt_rd_data = 32'h0000_0000;
            endcase
        end
    end

    // Read data stands only in the cycle after the strobe
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            rd_data_ff <= 32'h0000_0000;
        end else begin
            rd_data_ff <= nxt_rd_data;
        end
    end

    assign rd_data    = rd_data_ff;
    assign irq_master = irq_master_ff;
    assign irq_out    = irq_out_ff;
    assign wake_up    = wake_ff;
    assign asleep     = asleep_ff;

endmodule : eirq_core

//--- sim/eirq_core_sva.sv
// Checker of register reads, wake logic and status reflection of the interrupt block
`include "eirq_cfg.svh"
module eirq_core_sva
    import eirq_pkg::*;
(
    input wire logic         ref_clk,
    input wire logic         rst,
    input wire eirq_bus_type bus,
    input wire logic  [31:0] rd_data,
    input wire eirq_src_type src,
    input wire logic   [2:0] pin_in,
    input wire logic         deassert_hold,
    input wire logic         irq_master,
    input wire logic         irq_out,
    input wire logic         wake_up,
    input wire logic         asleep
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    AST_PROBE_READ: assert property ($past(bus.rd) && $past(bus.addr) == `EIRQ_OFS_PROBE
        |-> rd_data == 32'h8765_4321) else $error("probe read value wrong");
    AST_ENABLE_RSV: assert property ($past(bus.rd) && $past(bus.addr) == `EIRQ_OFS_ENABLE
        |-> (rd_data & ~32'h83BF_E7DF) == 32'h0) else $error("reserved enable bit set");
    AST_STATUS_RSV: assert property ($past(bus.rd) && $past(bus.addr) == `EIRQ_OFS_STATUS
        |-> (rd_data & ~32'h83BF_E7DF) == 32'h0) else $error("reserved status bit set");
    AST_RX_ERR_SEEN: assert property (src.rx_error ##1 !bus.wr
        ##1 (bus.rd && bus.addr == `EIRQ_OFS_STATUS) |=> rd_data[`EIRQ_BIT_RX_ERR])
        else $error("receive error flag not latched");
    // Four stable samples cover the two-flop synchroniser plus the status and read data flops
    AST_PHY_MIRROR: assert property ($past(bus.rd) && $past(bus.addr) == `EIRQ_OFS_STATUS
        && $past(src.phy_event, 2) == $past(src.phy_event)
        && $past(src.phy_event, 3) == $past(src.phy_event)
        && $past(src.phy_event, 4) == $past(src.phy_event)
        |-> rd_data[`EIRQ_BIT_PHY] == $past(src.phy_event)) else $error("phy flag not mirrored");
    AST_WAKE_PULSE: assert property (wake_up |=> !wake_up)
        else $error("wake pulse longer than one cycle");
    AST_WAKE_CAUSE: assert property (wake_up |-> $past(bus.wr) && $past(asleep)
        && $past(bus.addr) == `EIRQ_OFS_PROBE) else $error("wake without probe write");
    AST_SLEEP_HOLDS: assert property (asleep && !(bus.wr && bus.addr == `EIRQ_OFS_PROBE)
        |=> asleep) else $error("left sleep without probe write");
    AST_MASTER_READ: assert property ($past(bus.rd) && $past(bus.addr) == `EIRQ_OFS_STATE
        |-> rd_data[0] == $past(irq_master)) else $error("state read disagrees with master");
endmodule : eirq_core_sva

bind eirq_core eirq_core_sva eirq_core_sva_i (
    .ref_clk(ref_clk), .rst(rst), .bus(bus), .rd_data(rd_data), .src(src), .pin_in(pin_in),
    .deassert_hold(deassert_hold), .irq_master(irq_master), .irq_out(irq_out),
    .wake_up(wake_up), .asleep(asleep)
);

//--- sim/test_eirq_core.sv
// Self-checking bench of the interrupt status and enable block
`include "eirq_cfg.svh"
module test_eirq_core
    import eirq_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [7:0] a_sts = `EIRQ_OFS_STATUS;
    localparam logic [7:0] a_en  = `EIRQ_OFS_ENABLE;
    logic         ref_clk = 1'b0;
    logic         rst = 1'b1;
    eirq_bus_type bus = '0;
    eirq_src_type src = '0;
    logic   [2:0] pin_in = 3'h0;
    logic         deassert_hold = 1'b0;
    logic  [31:0] rd_data;
    logic         irq_master;
    logic         irq_out;
    logic         wake_up;
    logic         asleep;
    logic  [31:0] got;
    logic         wake_seen;
    int           error_cnt = 0;
    int           checks_done = 0;
    int           cycles = 0;
    logic  [31:0] exp_tab [21] = '{32'h0020_0000, 32'h0010_0000, 32'h0008_0000, 32'h0002_0000,
        32'h0001_0000, 32'h0000_8000, 32'h0, 32'h0000_4000, 32'h0000_2000, 32'h0000_0400, 32'h0,
        32'h0000_0200, 32'h0, 32'h0000_0100, 32'h0000_0080, 32'h0, 32'h0000_0040, 32'h0000_0010,
        32'h0000_0008, 32'h0, 32'h0};

    always #50 ref_clk = ~ref_clk;

    eirq_core eirq_core_i (
        .ref_clk(ref_clk), .rst(rst), .bus(bus), .rd_data(rd_data), .src(src), .pin_in(pin_in),
        .deassert_hold(deassert_hold), .irq_master(irq_master), .irq_out(irq_out),
        .wake_up(wake_up), .asleep(asleep)
    );

    task automatic conclude();
        if (error_cnt == 0 && checks_done > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : conclude

    // Generous ceiling: the whole sequence needs well under a thousand cycles
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            error_cnt++;
            conclude();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask : check

    // One strobe cycle, then idle; read data and wake pulse stand in the next cycle
    task automatic bus_op(input logic [7:0] a, input logic [31:0] d, input logic w);
        @(posedge ref_clk);
        bus <= '{addr: a, wdata: d, wr: w, rd: !w};
        @(posedge ref_clk);
        bus <= '0;
        #1;
        got = rd_data;
        wake_seen = wake_up;
    endtask : bus_op

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus_op(a, d, 1'b1);
    endtask : wr

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        bus_op(a, 32'h0, 1'b0);
        check(got, e);
    endtask : rd_chk

    task automatic settle(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : settle

    function automatic eirq_src_type src_of(input int k);
        eirq_src_type v;
        v = '0;
        case (k)
            0: v.tx_buffer_done = 1'b1;
            1: v.rx_xfer_done = 1'b1;
            2: v = '{timer_tick: 1'b1, timer_value: 16'hFFFF, default: '0};
            3: v.power_event = 1'b1;
            4: v.tx_status_overflow = 1'b1;
            5: v = '{rx_frame_end: 1'b1, rx_frame_bytes: 12'h801, default: '0};
            6: v = '{rx_frame_end: 1'b1, rx_frame_bytes: 12'h800, default: '0};
            7: v.rx_error = 1'b1;
            8: v.tx_error = 1'b1;
            9: v = '{tx_data_write: 1'b1, tx_data_full: 1'b1, default: '0};
            10: v.tx_data_write = 1'b1;
            11: v.tx_free_blocks = 8'h49;
            12: v.tx_free_blocks = 8'h48;
            13: v.tx_status_full = 1'b1;
            14: v.tx_status_used = 8'h06;
            15: v.tx_status_used = 8'h05;
            16: v.rx_frame_drop = 1'b1;
            17: v.rx_status_full = 1'b1;
            18: v.rx_status_used = 8'h04;
            19: v.rx_status_used = 8'h03;
            default: v = '{timer_tick: 1'b1, timer_value: 16'hFFFE, default: '0};
        endcase
        return v;
    endfunction : src_of

    initial begin
        repeat (20) @(posedge ref_clk);
        rst <= 1'b0;
        rd_chk(a_en, 32'h0);
        rd_chk(`EIRQ_OFS_LEVEL, 32'h4800_0000);
        rd_chk(`EIRQ_OFS_PROBE, 32'h8765_4321);
        rd_chk(8'h40, 32'h0);
        wr(a_en, 32'hFFFF_FFFF);
        rd_chk(a_en, 32'h83BF_E7DF);
        wr(a_en, 32'h0);
        wr(`EIRQ_OFS_LEVEL, 32'h4805_0003);
        rd_chk(`EIRQ_OFS_LEVEL, 32'h4805_0003);
        for (int k = 0; k < 21; k++) begin
            wr(a_sts, 32'hFFFF_FFFF);
            src <= src_of(k);
            @(posedge ref_clk);
            src <= '0;
            rd_chk(a_sts, exp_tab[k]);
            check({31'h0, irq_master}, 32'h0);
        end
        src.rx_error <= 1'b1;
        @(posedge ref_clk);
        src <= '0;
        wr(a_sts, 32'h0);
        rd_chk(a_sts, 32'h0000_4000);
        @(posedge ref_clk);
        bus <= '{addr: a_sts, wdata: 32'h0000_4000, wr: 1'b1, rd: 1'b0};
        src.rx_error <= 1'b1;
        @(posedge ref_clk);
        bus <= '0;
        src <= '0;
        rd_chk(a_sts, 32'h0000_4000);
        wr(a_sts, 32'h0000_4000);
        rd_chk(a_sts, 32'h0);
        src.phy_event <= 1'b1;
        settle(5);
        wr(a_sts, 32'hFFFF_FFFF);
        rd_chk(a_sts, 32'h0004_0000);
        src.phy_event <= 1'b0;
        wr(a_en, 32'h0000_4000);
        src.rx_error <= 1'b1;
        @(posedge ref_clk);
        src <= '0;
        settle(3);
        check({30'h0, irq_out, irq_master}, 32'h3);
        rd_chk(`EIRQ_OFS_STATE, 32'h3);
        deassert_hold <= 1'b1;
        settle(3);
        check({30'h0, irq_out, irq_master}, 32'h1);
        wr(a_en, 32'h0002_0000);
        src.power_event <= 1'b1;
        @(posedge ref_clk);
        src <= '0;
        settle(3);
        check({30'h0, irq_out, irq_master}, 32'h3);
        wr(a_sts, 32'hFFFF_FFFF);
        settle(3);
        check({30'h0, irq_out, irq_master}, 32'h0);
        deassert_hold <= 1'b0;
        wr(`EIRQ_OFS_CTRL, 32'h0000_000E);
        pin_in <= 3'h7;
        settle(6);
        rd_chk(a_sts, 32'h0000_0007);
        wr(`EIRQ_OFS_CTRL, 32'h0000_007E);
        wr(a_sts, 32'h0000_0007);
        pin_in <= 3'h0;
        settle(6);
        rd_chk(a_sts, 32'h0000_0007);
        wr(`EIRQ_OFS_CTRL, 32'h0000_0080);
        // A power event must leave the block asleep; only the probe write wakes it
        src.power_event <= 1'b1;
        @(posedge ref_clk);
        src <= '0;
        settle(3);
        check({31'h0, asleep}, 32'h1);
        wr(`EIRQ_OFS_PROBE, 32'h0);
        check({31'h0, wake_seen}, 32'h1);
        settle(2);
        check({31'h0, asleep}, 32'h0);
        conclude();
    end
endmodule : test_eirq_core
